//--- nvs_pkg.sv
// shared constants and types of the paged memory serial slave
package nvs_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] DEV_ADDR_BASE = 4'ha;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] SRAM_BASE = 8'hf8;
  localparam logic [4:0] SHADOW_ROW = 5'h1e;
  localparam logic [4:0] ROW_RESET = 5'h00;
  localparam logic [2:0] STRAP_RESET = 3'h0;
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_MEM, ST_MEM_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } nvs_state_t;
endpackage

//--- nvs_fifo.sv
// parameterised fifo with registered output stage
`timescale 1ns/1ps
module nvs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign push = i_in_valid && o_in_ready;
  // move the head into the output register when it is empty or taken
  assign pop = (count_reg != '0) && (!o_out_valid || i_out_ready);

  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_out_valid <= 1'b0;
      o_out_data <= '0;
    end else if (i_ce) begin
      if (pop) begin
        o_out_valid <= 1'b1;
        o_out_data <= mem[rd_ptr_reg];
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
    end
  end
endmodule // nvs_fifo

//--- nvs_slave.sv
// two-wire serial slave giving byte access to a paged memory
`timescale 1ns/1ps
// Overview of operation
// - pointer advances after every acknowledged data byte
// - on writes pointer wraps to start of same row, reads run on into the next row
// - rows aligned on multiples of eight
// - stop after eeprom write starts timed commit
// - own address not acknowledged during commit
// - commit reprograms whole eight byte page
// - reads come from the current pointer
// - dummy write loads pointer for random read
// - each master ack brings another byte
// - byte after write address loads pointer
// - mismatched address ignored until next start
// - seven bit address, low three from straps
// - shadow only bit suppresses eeprom commit of the shadow row
module nvs_slave #(
  parameter int T_COMMIT_NS = 10_000_000
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  input wire logic i_addr_strap_bit0,
  input wire logic i_addr_strap_bit1,
  input wire logic i_addr_strap_bit2,
  input wire logic i_shadow_only,
  output logic [7:0] o_mem_rd_addr,
  input wire logic [7:0] i_mem_rd_data,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_commit_valid,
  output logic [4:0] o_commit_row,
  output logic o_busy
);
  localparam int COMMIT_CYCLES =
    (T_COMMIT_NS + nvs_pkg::CLK_PERIOD_NS - 1) / nvs_pkg::CLK_PERIOD_NS;

  // advance within the row only, upper bits pick the row
  function automatic logic [7:0] row_next(input logic [7:0] a);
    row_next = {a[7:3], a[2:0] + 3'h1};
  endfunction

  function automatic logic needs_commit(input logic [7:0] a,
                                        input logic shadow_only);
    needs_commit = (a < nvs_pkg::SRAM_BASE) &&
                   !(shadow_only && (a[7:3] == nvs_pkg::SHADOW_ROW));
  endfunction

  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic [2:0] strap_s1_reg, strap_s2_reg;
  nvs_pkg::nvs_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] addr_cnt_reg;
  logic touched_reg;
  logic [31:0] busy_cnt_reg;
  logic scl_rise, scl_fall, start_ev, stop_ev, byte_done;
  logic dev_match, push, fifo_ready;
  logic [15:0] fifo_out;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      strap_s1_reg <= nvs_pkg::STRAP_RESET;
      strap_s2_reg <= nvs_pkg::STRAP_RESET;
    end else if (i_ce) begin
      scl_s1_reg <= i_scl;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= i_sda;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
      strap_s1_reg <= {i_addr_strap_bit2, i_addr_strap_bit1,
                       i_addr_strap_bit0};
      strap_s2_reg <= strap_s1_reg;
    end
  end

  assign scl_rise = scl_s2_reg && !scl_d_reg;
  assign scl_fall = !scl_s2_reg && scl_d_reg;
  assign start_ev = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  assign stop_ev = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;
  assign byte_done = scl_fall && (bit_cnt_reg == nvs_pkg::BYTE_BITS);
  assign dev_match = (shift_reg[7:1] ==
                      {nvs_pkg::DEV_ADDR_BASE, strap_s2_reg});
  assign push = (state_reg == nvs_pkg::ST_WR) && byte_done && fifo_ready;

  // bus sequencer; oe low pulls the data line low
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= nvs_pkg::ST_IDLE;
      bit_cnt_reg <= nvs_pkg::BIT_ZERO;
      shift_reg <= nvs_pkg::ADDR_RESET;
      o_sda_oe_n <= 1'b1;
    end else if (i_ce) begin
      if (start_ev) begin
        state_reg <= nvs_pkg::ST_DEV;
        bit_cnt_reg <= nvs_pkg::BIT_ZERO;
        o_sda_oe_n <= 1'b1;
      end else if (stop_ev) begin
        state_reg <= nvs_pkg::ST_IDLE;
        o_sda_oe_n <= 1'b1;
      end else begin
        unique case (state_reg)
          nvs_pkg::ST_IDLE: begin
          end
          nvs_pkg::ST_DEV, nvs_pkg::ST_MEM, nvs_pkg::ST_WR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s2_reg};
              bit_cnt_reg <= bit_cnt_reg + nvs_pkg::BIT_ONE;
            end else if (byte_done) begin
              if (state_reg == nvs_pkg::ST_DEV) begin
                state_reg <= nvs_pkg::ST_DEV_ACK;
                o_sda_oe_n <= !(dev_match && (busy_cnt_reg == '0));
              end else if (state_reg == nvs_pkg::ST_MEM) begin
                state_reg <= nvs_pkg::ST_MEM_ACK;
                o_sda_oe_n <= 1'b0;
              end else begin
                state_reg <= nvs_pkg::ST_WR_ACK;
                o_sda_oe_n <= !fifo_ready;
              end
            end
          end
          nvs_pkg::ST_DEV_ACK: begin
            if (scl_fall) begin
              if (o_sda_oe_n) begin
                state_reg <= nvs_pkg::ST_IDLE;
              end else if (shift_reg[0]) begin
                state_reg <= nvs_pkg::ST_RD;
                shift_reg <= i_mem_rd_data;
                o_sda_oe_n <= i_mem_rd_data[7];
                bit_cnt_reg <= nvs_pkg::BIT_ONE;
              end else begin
                state_reg <= nvs_pkg::ST_MEM;
                o_sda_oe_n <= 1'b1;
                bit_cnt_reg <= nvs_pkg::BIT_ZERO;
              end
            end
          end
          nvs_pkg::ST_MEM_ACK, nvs_pkg::ST_WR_ACK: begin
            if (scl_fall) begin
              state_reg <= o_sda_oe_n ? nvs_pkg::ST_IDLE : nvs_pkg::ST_WR;
              o_sda_oe_n <= 1'b1;
              bit_cnt_reg <= nvs_pkg::BIT_ZERO;
            end
          end
          nvs_pkg::ST_RD: begin
            if (byte_done) begin
              state_reg <= nvs_pkg::ST_RD_ACK;
              o_sda_oe_n <= 1'b1;
            end else if (scl_fall) begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              o_sda_oe_n <= shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + nvs_pkg::BIT_ONE;
            end
          end
          nvs_pkg::ST_RD_ACK: begin
            if (scl_rise && sda_s2_reg) begin
              state_reg <= nvs_pkg::ST_IDLE;
            end else if (scl_fall) begin
              state_reg <= nvs_pkg::ST_RD;
              shift_reg <= i_mem_rd_data;
              o_sda_oe_n <= i_mem_rd_data[7];
              bit_cnt_reg <= nvs_pkg::BIT_ONE;
            end
          end
        endcase
      end
    end
  end

  // address counter
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      addr_cnt_reg <= nvs_pkg::ADDR_RESET;
    end else if (i_ce) begin
      if ((state_reg == nvs_pkg::ST_MEM) && byte_done) begin
        addr_cnt_reg <= shift_reg;
      end else if (push) begin
        addr_cnt_reg <= row_next(addr_cnt_reg);
      end else if ((state_reg == nvs_pkg::ST_RD_ACK) && scl_rise) begin
        addr_cnt_reg <= addr_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_mem_rd_addr <= nvs_pkg::ADDR_RESET;
      o_sda <= 1'b0;
    end else if (i_ce) begin
      o_mem_rd_addr <= addr_cnt_reg;
      o_sda <= 1'b0;
    end
  end

  // page commit request and busy window
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      touched_reg <= 1'b0;
      o_commit_row <= nvs_pkg::ROW_RESET;
      o_commit_valid <= 1'b0;
    end else if (i_ce) begin
      o_commit_valid <= 1'b0;
      if (stop_ev) begin
        o_commit_valid <= touched_reg;
        touched_reg <= 1'b0;
      end else if (push && needs_commit(addr_cnt_reg, i_shadow_only)) begin
        touched_reg <= 1'b1;
        o_commit_row <= addr_cnt_reg[7:3];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      busy_cnt_reg <= '0;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      if (stop_ev && touched_reg) begin
        busy_cnt_reg <= 32'(COMMIT_CYCLES);
        o_busy <= 1'b1;
      end else if (busy_cnt_reg != '0) begin
        busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001;
        o_busy <= (busy_cnt_reg != 32'h0000_0001);
      end
    end
  end

  nvs_fifo #(
    .WIDTH(nvs_pkg::FIFO_WIDTH),
    .DEPTH(nvs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_in_valid(push),
    .o_in_ready(fifo_ready),
    .i_in_data({addr_cnt_reg, shift_reg}),
    .o_out_valid(o_wr_valid),
    .i_out_ready(i_wr_ready),
    .o_out_data(fifo_out)
  );
  assign o_wr_addr = fifo_out[15:8];
  assign o_wr_data = fifo_out[7:0];

  row_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && push |=> addr_cnt_reg[7:3] == $past(addr_cnt_reg[7:3]))
    else $error("pointer left its row");
  addr_incr_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && push |=> addr_cnt_reg[2:0] == $past(addr_cnt_reg[2:0]) + 3'h1)
    else $error("pointer did not advance on write");
  busy_nack_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_reg == nvs_pkg::ST_DEV_ACK && busy_cnt_reg > 32'h0000_0002
    |-> o_sda_oe_n)
    else $error("address acknowledged while busy");
  commit_busy_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_commit_valid |-> o_busy && !$past(o_commit_valid))
    else $error("commit without busy window");
  shadow_skip_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && push && !touched_reg && i_shadow_only &&
    addr_cnt_reg[7:3] == nvs_pkg::SHADOW_ROW |=> !touched_reg)
    else $error("shadow only write armed a commit");
  read_adv_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && state_reg == nvs_pkg::ST_RD_ACK && scl_rise && !start_ev &&
    !stop_ev |=> addr_cnt_reg == $past(addr_cnt_reg) + 8'h01)
    else $error("pointer did not advance on read");
  nack_release_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_reg == nvs_pkg::ST_RD_ACK |-> o_sda_oe_n)
    else $error("data line held during master ack bit");
  mismatch_ign_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_reg == nvs_pkg::ST_DEV_ACK && !dev_match |-> o_sda_oe_n ##1
    (state_reg != nvs_pkg::ST_MEM && state_reg != nvs_pkg::ST_RD))
    else $error("foreign address answered");
  ptr_load_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && state_reg == nvs_pkg::ST_MEM && byte_done && !start_ev &&
    !stop_ev |=> addr_cnt_reg == $past(shift_reg) ##2
    o_mem_rd_addr == $past(addr_cnt_reg, 2))
    else $error("pointer not loaded from address byte");
  commit_row_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && push && needs_commit(addr_cnt_reg, i_shadow_only) && !stop_ev
    |=> o_commit_row == $past(addr_cnt_reg[7:3]))
    else $error("commit row not the written row");
endmodule // nvs_slave

//--- nvs_master_model.sv
// two-wire bus master model that drives the slave under test
`timescale 1ns/1ps
module nvs_master_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // quarter of the 80 ns bus clock period
  task automatic q();
    repeat (4) @(negedge i_clk);
  endtask
  task automatic start();
    o_sda = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda = 1'b0;
    q();
    o_scl = 1'b0;
    q();
  endtask
  task automatic stop();
    o_sda = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    o_sda = 1'b1;
    q();
    q();
  endtask
  task automatic bit_out(input logic b);
    o_sda = b;
    q();
    o_scl = 1'b1;
    q();
    q();
    o_scl = 1'b0;
    q();
  endtask
  // line released, the pull-up gives a one unless the slave pulls low
  task automatic bit_in(output logic b);
    o_sda = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    b = i_sda;
    q();
    o_scl = 1'b0;
    q();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic nak;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(nak);
    ack = !nak;
  endtask
  task automatic rd_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
  endtask
endmodule // nvs_master_model

//--- nvs_slave_test.sv
// self-checking bench of the paged memory serial slave
`timescale 1ns/1ps
module nvs_slave_test;
  localparam int T_COMMIT = 1000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] strap = 3'h0;
  logic shadow = 1'b0;
  logic stall = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic wr_ready = 1'b0;
  logic scl, m_sda, o_sda, oe_n, wr_valid, commit_valid, busy, ack;
  logic [7:0] rd_addr, wr_addr, wr_data;
  logic [4:0] commit_row, last_row;
  logic [7:0] hw [256];
  logic [7:0] exp_mem [256];
  logic [7:0] ptr = 8'h00;
  wire sda_line = m_sda & (oe_n | o_sda);
  integer seed = 97261;
  int err_total = 0;
  int total_checks = 0;
  int commits = 0;
  int c0;
  always #2.5 clk = ~clk;
  nvs_master_model i_mst (.i_clk(clk), .i_sda(sda_line), .o_scl(scl),
    .o_sda(m_sda));
  nvs_slave #(.T_COMMIT_NS(T_COMMIT)) i_dut (.i_clk(clk), .i_rstn(rstn),
    .i_ce(1'b1), .i_scl(scl), .i_sda(sda_line), .o_sda(o_sda),
    .o_sda_oe_n(oe_n), .i_addr_strap_bit0(strap[0]),
    .i_addr_strap_bit1(strap[1]), .i_addr_strap_bit2(strap[2]),
    .i_shadow_only(shadow), .o_mem_rd_addr(rd_addr),
    .i_mem_rd_data(rd_data), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data),
    .o_commit_valid(commit_valid), .o_commit_row(commit_row),
    .o_busy(busy));
  initial begin
    for (int i = 0; i < 256; i++) begin
      hw[i] = 8'(i * 3);
      exp_mem[i] = 8'(i * 3);
    end
  end
  // memory side: one cycle read latency, randomly stalled write port
  always @(negedge clk) begin
    rd_data <= hw[rd_addr];
    wr_ready <= stall ? 1'b0 : 1'($random(seed));
  end
  always @(posedge clk) begin
    if (wr_valid && wr_ready) hw[wr_addr] <= wr_data;
    if (commit_valid) begin
      commits <= commits + 1;
      last_row <= commit_row;
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic dev(input logic rw, input logic [2:0] s);
    i_mst.start();
    i_mst.wr_byte({nvs_pkg::DEV_ADDR_BASE, s, rw}, ack);
  endtask
  task automatic wr_seq(input logic [7:0] a, input int n, input bit p);
    logic [7:0] d;
    dev(1'b0, strap);
    chk(8'(ack), 8'h01);
    i_mst.wr_byte(a, ack);
    chk(8'(ack), 8'h01);
    ptr = a;
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      i_mst.wr_byte(d, ack);
      // the output stage holds one byte beyond the buffer depth
      chk(8'(ack), 8'(i <= nvs_pkg::FIFO_DEPTH));
      if (ack) exp_mem[ptr] = d;
      ptr = {ptr[7:3], ptr[2:0] + 3'h1};
    end
    if (p) i_mst.stop();
  endtask
  task automatic rd_seq(input int n);
    logic [7:0] d;
    for (int k = 0; k < 400 && wr_valid; k++) @(negedge clk);
    dev(1'b1, strap);
    chk(8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      i_mst.rd_byte(d, i == n - 1);
      chk(d, exp_mem[ptr]);
      ptr = ptr + 8'h01;
    end
    chk(8'(oe_n), 8'h01);
    i_mst.stop();
    chk(8'(oe_n), 8'h01);
  endtask
  task automatic poll();
    ack = 1'b0;
    for (int k = 0; k < 20 && !ack; k++) begin
      dev(1'b0, strap);
      i_mst.stop();
    end
    chk(8'(ack), 8'h01);
  endtask
  initial begin
    #300_000;
    err_total++;
    conclude();
  end
  initial begin
    strap = 3'($random(seed));
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    chk(8'(oe_n), 8'h01);
    chk(8'(busy), 8'h00);
    chk(8'(wr_valid), 8'h00);
    repeat (4) @(negedge clk);
    $display("test reset done");
    wr_seq(8'h0d, 10, 1);
    dev(1'b0, strap);
    chk(8'(ack), 8'h00);
    chk(8'(busy), 8'h01);
    i_mst.stop();
    chk(8'(commits), 8'h01);
    chk(8'(last_row), 8'h01);
    poll();
    $display("test page write done");
    wr_seq(8'h08, 0, 0);
    rd_seq(9);
    rd_seq(1);
    chk(8'(commits), 8'h01);
    $display("test reads done");
    dev(1'b0, strap ^ 3'h1);
    chk(8'(ack), 8'h00);
    i_mst.wr_byte(8'h20, ack);
    i_mst.wr_byte(8'h55, ack);
    i_mst.stop();
    chk(8'(wr_valid), 8'h00);
    chk(8'(commits), 8'h01);
    $display("test foreign address done");
    stall = 1'b1;
    wr_seq(8'h30, 18, 1);
    stall = 1'b0;
    poll();
    wr_seq(8'h30, 0, 0);
    rd_seq(8);
    $display("test full buffer done");
    c0 = commits;
    shadow = 1'b1;
    wr_seq(8'hf4, 1, 1);
    repeat (20) @(negedge clk);
    chk(8'(commits - c0), 8'h00);
    shadow = 1'b0;
    wr_seq(8'hf2, 1, 1);
    repeat (20) @(negedge clk);
    chk(8'(commits - c0), 8'h01);
    chk(8'(last_row), 8'(nvs_pkg::SHADOW_ROW));
    poll();
    wr_seq(8'hf2, 0, 0);
    rd_seq(3);
    $display("test shadow row done");
    conclude();
  end
endmodule // nvs_slave_test
